// ### fmi_fifo.sv
`timescale 1ns/1ps
module fmi_fifo #(
   parameter int W = 28,
   parameter int D = 16
) (
   input  wire logic         i_clk,
   input  wire logic         i_sys_rst,
   input  wire logic         i_in_valid,
   input  wire logic [W-1:0] i_in_data,
   output logic              o_in_ready,
   output logic              o_out_valid,
   output logic [W-1:0]      o_out_data,
   input  wire logic         i_out_ready
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
      logic          in_rdy;
      logic          out_vld;
   } fmi_fifo_st_t;

   fmi_fifo_st_t r, next_r;
   logic [W-1:0] mem [0:D-1];
   logic         push, pop;

   assign push = i_in_valid & r.in_rdy;
   assign pop  = i_out_ready & r.out_vld;

   always_comb begin
      next_r = r;
      if (push) begin
         next_r.wp = r.wp + 1'b1;
      end
      if (pop) begin
         next_r.rp = r.rp + 1'b1;
      end
      next_r.cnt     = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      next_r.in_rdy  = (next_r.cnt != D[AW:0]);
      next_r.out_vld = (next_r.cnt != '0);
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r <= '{wp: '0, rp: '0, cnt: '0, in_rdy: 1'b1, out_vld: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[r.wp] <= i_in_data;
      end
   end

   assign o_in_ready  = r.in_rdy;
   assign o_out_valid = r.out_vld;
   assign o_out_data  = mem[r.rp];
endmodule

// ### fmi_link_if.sv
`timescale 1ns/1ps
interface fmi_link_if;
   logic scl;
   logic sda_m_oe;
   logic sda_t_oe;
   logic sda;

   // open-drain wire with pull-up: low while either end drives
   assign sda = ~(sda_m_oe | sda_t_oe);

   modport master (output scl, output sda_m_oe, input sda);
   modport target (input scl, output sda_t_oe, input sda);
endinterface

// ### fmi_master.sv
`timescale 1ns/1ps
module fmi_master
   import fmi_pkg::*;
(
   input  wire logic                 i_clk,
   input  wire logic                 i_sys_rst,
   fmi_link_if.master                link,
   input  wire logic                 i_cmd_valid,
   input  wire logic [FMI_CMD_W-1:0] i_cmd_data,
   output logic                      o_cmd_ready,
   output logic                      o_busy,
   output logic                      o_rd_valid,
   output logic [7:0]                o_rd_data,
   output logic                      o_ack_err
);
   typedef enum logic [3:0] {
      M_IDLE  = 4'b0001,
      M_START = 4'b0010,
      M_BIT   = 4'b0100,
      M_STOP  = 4'b1000
   } fmi_mst_t;

   typedef struct packed {
      fmi_mst_t             st;
      logic [FMI_DIV_W-1:0] div;
      logic [1:0]           q;
      logic [3:0]           bitn;
      logic [2:0]           step;
      logic [7:0]           sh;
      logic [7:0]           rx;
      logic [FMI_CMD_W-1:0] cmd;
      logic                 scl;
      logic                 oe;
      logic [2:0]           sy;
      logic                 sda_f;
      logic                 busy;
      logic                 rd_valid;
      logic [7:0]           rd_data;
      logic                 ack_err;
   } fmi_mst_st_t;

   fmi_mst_st_t          r, next_r;
   logic                 tick, f_valid, f_ready;
   logic [FMI_CMD_W-1:0] f_data;

   function automatic logic [7:0] step_byte(input logic [2:0] s,
                                            input logic [FMI_CMD_W-1:0] c);
      // (RULE19) address word layout
      // (RULE20) direction bit last
      case (s)
         3'd0: step_byte = {FMI_TYPE_CODE, c[FMI_CMD_SEL +: 3],
                            FMI_DIR_WRITE};
         3'd1: step_byte = c[FMI_CMD_ADDR + 8 +: 8];
         3'd2: step_byte = c[FMI_CMD_ADDR +: 8];
         3'd3: step_byte = c[FMI_CMD_DATA +: 8];
         3'd4: step_byte = {FMI_TYPE_CODE, c[FMI_CMD_SEL +: 3],
                            FMI_DIR_READ};
         default: step_byte = 8'hFF;
      endcase
   endfunction

   fmi_fifo #(.W(FMI_CMD_W), .D(FMI_FIFO_DEPTH)) u_fifo (
      .i_clk       (i_clk),
      .i_sys_rst   (i_sys_rst),
      .i_in_valid  (i_cmd_valid),
      .i_in_data   (i_cmd_data),
      .o_in_ready  (o_cmd_ready),
      .o_out_valid (f_valid),
      .o_out_data  (f_data),
      .i_out_ready (f_ready)
   );

   // (RULE17) quarter bit of 1 MHz
   assign tick    = (r.div == FMI_DIV_W'(FMI_QTR_CYC - 1));
   assign f_ready = tick & (r.st == M_IDLE);

   always_comb begin
      next_r = r;
      next_r.rd_valid = 1'b0;
      next_r.ack_err  = 1'b0;
      next_r.div      = tick ? '0 : r.div + 1'b1;
      next_r.sy       = {r.sy[1:0], link.sda};
      if (r.sy[1] == r.sy[2]) begin
         next_r.sda_f = r.sy[2];
      end
      if (tick) begin
         next_r.q = (r.st == M_IDLE) ? 2'd0 : r.q + 2'd1;
         case (r.st)
            M_IDLE: begin
               next_r.scl = 1'b1;
               next_r.oe  = 1'b0;
               if (f_valid) begin
                  next_r.cmd  = f_data;
                  next_r.st   = M_START;
                  next_r.step = 3'd0;
                  next_r.busy = 1'b1;
               end
            end
            M_START: begin
               // (RULE13) data falls, clock high
               case (r.q)
                  2'd0: next_r.oe  = 1'b0;
                  2'd1: next_r.scl = 1'b1;
                  2'd2: next_r.oe  = 1'b1;
                  default: begin
                     next_r.scl  = 1'b0;
                     next_r.st   = M_BIT;
                     next_r.bitn = '0;
                     next_r.sh   = step_byte(r.step, r.cmd);
                  end
               endcase
            end
            M_BIT: begin
               case (r.q)
                  // (RULE12) data set while clock low
                  // (RULE18) ninth bit released
                  2'd0: next_r.oe  = (r.bitn < 4'd8) ? ~r.sh[7] : 1'b0;
                  2'd1: next_r.scl = 1'b1;
                  2'd2: begin
                     if (r.bitn < 4'd8) begin
                        next_r.rx = {r.rx[6:0], r.sda_f};
                        next_r.sh = {r.sh[6:0], 1'b1};
                     end else if (r.step != 3'd5 && r.sda_f) begin
                        next_r.ack_err = 1'b1;
                        next_r.st      = M_STOP;
                     end
                  end
                  default: begin
                     next_r.scl  = 1'b0;
                     next_r.bitn = r.bitn + 4'd1;
                     if (r.bitn == 4'd8) begin
                        next_r.bitn = '0;
                        if (r.step == 3'd2 && r.cmd[FMI_CMD_RW]) begin
                           next_r.st   = M_START;
                           next_r.step = 3'd4;
                        end else if (r.step == 3'd3 || r.step == 3'd5) begin
                           next_r.st       = M_STOP;
                           next_r.rd_valid = (r.step == 3'd5);
                           next_r.rd_data  = r.rx;
                        end else begin
                           next_r.step = r.step + 3'd1;
                           next_r.sh   = step_byte(r.step + 3'd1, r.cmd);
                        end
                     end
                  end
               endcase
            end
            M_STOP: begin
               // (RULE14) data rises, clock high
               case (r.q)
                  2'd0: begin
                     next_r.scl = 1'b0;
                     next_r.oe  = 1'b1;
                  end
                  2'd1: next_r.scl = 1'b1;
                  2'd2: next_r.oe  = 1'b0;
                  default: begin
                     next_r.st   = M_IDLE;
                     next_r.busy = 1'b0;
                  end
               endcase
            end
            default: begin
               next_r.st = M_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         r <= '{st: M_IDLE, div: '0, q: 2'h0, bitn: 4'h0, step: 3'h0,
                sh: 8'h00, rx: 8'h00, cmd: '0, scl: 1'b1, oe: 1'b0,
                sy: 3'h7, sda_f: 1'b1, busy: 1'b0, rd_valid: 1'b0,
                rd_data: 8'h00, ack_err: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // (RULE11) master alone makes clock
   assign link.scl      = r.scl;
   assign link.sda_m_oe = r.oe;
   assign o_busy        = r.busy;
   assign o_rd_valid    = r.rd_valid;
   assign o_rd_data     = r.rd_data;
   assign o_ack_err     = r.ack_err;
endmodule

// ### fmi_pkg.sv
package fmi_pkg;
   // system clock and serial clock rates
   localparam int FMI_CLK_HZ     = 100_000_000;
   localparam int FMI_SCL_FMP_HZ = 1_000_000;
   localparam int FMI_SCL_HS_HZ  = 3_400_000;
   // quarter of one serial bit, in system clocks (rounded down)
   localparam int FMI_QTR_CYC    = FMI_CLK_HZ / (4 * FMI_SCL_FMP_HZ);
   localparam int FMI_DIV_W      = $clog2(FMI_QTR_CYC);
   // array geometry
   localparam int FMI_MEM_DEPTH  = 65536;
   localparam int FMI_AW         = 16;
   localparam int FMI_DW         = 8;
   // address word type code: arbitrary value
   localparam logic [3:0] FMI_TYPE_CODE = 4'h6;
   // direction bit of the address word
   localparam logic FMI_DIR_WRITE = 1'b0;
   localparam logic FMI_DIR_READ  = 1'b1;
   // command word for the master end: {rw, sel, addr, data}
   localparam int FMI_CMD_W      = 28;
   localparam int FMI_CMD_RW     = 27;
   localparam int FMI_CMD_SEL    = 24;
   localparam int FMI_CMD_ADDR   = 8;
   localparam int FMI_CMD_DATA   = 0;
   localparam int FMI_FIFO_DEPTH = 16;
   // pin synchroniser length
   localparam int FMI_SYNC_N     = 3;
   // reset values
   localparam logic [15:0] FMI_PTR_RST = 16'h0000;
endpackage

// ### fmi_props.sv
`timescale 1ns/1ps
module fmi_props (
   input  wire logic i_clk,
   input  wire logic i_sys_rst,
   input  wire logic scl,
   input  wire logic sda_m_oe,
   input  wire logic sda_t_oe,
   input  wire logic sda
);
   logic       scl_q;
   logic       m_q;
   logic [7:0] low_cnt;
   logic [7:0] per_cnt;
   logic [3:0] bitn;

   default clocking @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   // low_cnt and per_cnt saturate so a long idle cannot wrap into a false pass
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         scl_q   <= 1'b1;
         m_q     <= 1'b0;
         low_cnt <= 8'h00;
         per_cnt <= 8'hFF;
         bitn    <= 4'h0;
      end else begin
         scl_q   <= scl;
         m_q     <= sda_m_oe;
         low_cnt <= (!scl && scl_q) ? 8'h01 :
                    (low_cnt == 8'hFF) ? low_cnt : low_cnt + 8'h01;
         per_cnt <= (scl && !scl_q) ? 8'h01 :
                    (per_cnt == 8'hFF) ? per_cnt : per_cnt + 8'h01;
         if (scl && scl_q && sda_m_oe && !m_q) begin
            bitn <= 4'h0;
         end else if (scl && !scl_q) begin
            bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
         end
      end
   end

   chk_idle_after_reset: assert property (
      $fell(i_sys_rst) |-> scl && !sda_m_oe && !sda_t_oe)
      else $error("link not idle after reset");
   chk_scl_high_width: assert property (
      $rose(scl) |-> scl [*8]) else $error("serial clock high too short");
   chk_scl_low_width: assert property (
      $fell(scl) |-> !scl [*8]) else $error("serial clock low too short");
   chk_scl_period_min: assert property (
      (scl && !scl_q) |-> per_cnt >= 8'h64)
      else $error("serial clock faster than allowed");
   chk_tgt_scl_low: assert property (
      $changed(sda_t_oe) |-> !scl && !$past(scl))
      else $error("target moved data while clock high");
   chk_tgt_after_fall: assert property (
      $changed(sda_t_oe) |-> low_cnt <= 8'h08)
      else $error("target output late after clock fall");
   chk_start_released: assert property (
      (scl && $past(scl) && $fell(sda)) |-> !sda_t_oe)
      else $error("target driving at start");
   chk_stop_standby: assert property (
      (scl && $past(scl) && $rose(sda)) |-> !sda_t_oe [*4])
      else $error("target driving after stop");
   chk_ninth_tx_free: assert property (
      (scl && !scl_q && bitn == 4'h8) |-> !sda_m_oe)
      else $error("master holds data line on ninth clock");
endmodule

// ### fmi_target.sv
// Summary of operation
// (RULE1) array of 65,536 eight-bit locations
// (RULE2) act only when select code matches
// (RULE3) open select pins read as low
// (RULE4) eight memories share bus, master addresses one
// (RULE5) drive SDA low only, else release
// (RULE6) sample on SCL rise, drive on fall
// (RULE7) write protect high blocks all writes
// (RULE8) write protect low allows all writes
// (RULE9) reads served whatever write protect says
// (RULE10) open write protect pin reads low
// (RULE11) target only; master starts, makes SCL
// (RULE12) SDA changes while SCL low, except start/stop
// (RULE13) SDA fall with SCL high starts
// (RULE14) stop ends read, back to standby
// (RULE15) stop ends write, back to standby
// (RULE16) no programming delay after write stop
// (RULE17) SCL up to 3.4 MHz / 1 MHz
// (RULE18) receiver acknowledges low on ninth clock
// (RULE19) first byte: type, select bits, direction
// (RULE20) direction zero writes, one reads
// (RULE21) mismatch: no acknowledge, standby till start
// (RULE22) protected writes acknowledged, contents kept
`timescale 1ns/1ps
module fmi_target
   import fmi_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_sys_rst,
   fmi_link_if.target       link,
   input  wire logic [2:0]  i_dev_sel,
   input  wire logic        i_write_protect,
   output logic             o_busy,
   output logic             o_wr_pulse,
   output logic             o_wr_blocked
);
   typedef enum logic [4:0] {
      T_IDLE = 5'b00001,
      T_RX   = 5'b00010,
      T_RACK = 5'b00100,
      T_TX   = 5'b01000,
      T_MACK = 5'b10000
   } fmi_tst_t;

   // pin vector: {scl, sda, wp, sel[2:0]}
   localparam int PS = 5;
   localparam int PD = 4;
   localparam int PW = 3;

   typedef struct packed {
      fmi_tst_t          st;
      logic [5:0]        s1;
      logic [5:0]        s2;
      logic [5:0]        s3;
      logic [5:0]        filt;
      logic [7:0]        sh;
      logic [3:0]        bitn;
      logic [1:0]        byten;
      logic              rd;
      logic [FMI_AW-1:0] ptr;
      logic              sda_oe;
      logic              busy;
      logic              wr_pulse;
      logic              wr_blocked;
   } fmi_tgt_st_t;

   fmi_tgt_st_t r, next_r;

   // (RULE1) full array held here
   logic [FMI_DW-1:0] mem [0:FMI_MEM_DEPTH-1];
   logic              mem_we;
   logic [FMI_AW-1:0] mem_wa;
   logic [FMI_DW-1:0] mem_wd;
   logic [FMI_DW-1:0] rdata;
   logic              scl_rise, scl_fall, start_c, stop_c, sda_in;
   logic [7:0]        rx_byte;

   assign rdata = mem[r.ptr];

   always_comb begin
      next_r = r;
      next_r.wr_pulse   = 1'b0;
      next_r.wr_blocked = 1'b0;
      mem_we = 1'b0;
      mem_wa = r.ptr;
      mem_wd = '0;
      next_r.s1 = {link.scl, link.sda, i_write_protect, i_dev_sel};
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      // (RULE17) filter lag short of fast SCL
      // a pin level counts once two later stages agree
      for (int i = 0; i < 6; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            next_r.filt[i] = r.s2[i];
         end
      end
      sda_in   = next_r.filt[PD];
      // (RULE6) edges of the sampled clock
      scl_rise = next_r.filt[PS] & ~r.filt[PS];
      scl_fall = ~next_r.filt[PS] & r.filt[PS];
      // (RULE13) SDA fall while SCL high
      start_c  = r.filt[PS] & next_r.filt[PS] & r.filt[PD] & ~sda_in;
      // (RULE14) SDA rise while SCL high
      stop_c   = r.filt[PS] & next_r.filt[PS] & ~r.filt[PD] & sda_in;
      rx_byte  = {r.sh[6:0], sda_in};

      if (start_c) begin
         next_r.st     = T_RX;
         next_r.bitn   = '0;
         next_r.byten  = '0;
         next_r.sda_oe = 1'b0;
         next_r.busy   = 1'b1;
      end else if (stop_c) begin
         // (RULE15) stop ends any transfer
         // (RULE16) no programming delay follows
         next_r.st     = T_IDLE;
         next_r.sda_oe = 1'b0;
         next_r.busy   = 1'b0;
      end else begin
         case (r.st)
            T_IDLE: begin
               next_r.sda_oe = 1'b0;
            end
            T_RX: begin
               if (scl_rise && r.bitn < 4'd8) begin
                  // (RULE6) capture on rising edge
                  next_r.sh   = rx_byte;
                  next_r.bitn = r.bitn + 4'd1;
                  if (r.bitn == 4'd7) begin
                     case (r.byten)
                        2'd0: begin
                           // (RULE2) act on own code only
                           // (RULE4) one of eight codes
                           // (RULE19) type, select, direction
                           if (rx_byte[7:4] == FMI_TYPE_CODE &&
                               rx_byte[3:1] == r.filt[PW-1:0]) begin
                              // (RULE20) direction bit
                              next_r.rd = (rx_byte[0] == FMI_DIR_READ);
                           end else begin
                              // (RULE21) no acknowledge, standby
                              next_r.st   = T_IDLE;
                              next_r.busy = 1'b0;
                           end
                        end
                        2'd1: next_r.ptr[15:8] = rx_byte;
                        2'd2: next_r.ptr[7:0]  = rx_byte;
                        default: begin
                           if (!r.filt[PD - 1]) begin
                              // (RULE8) writable when protect low
                              mem_we = 1'b1;
                              mem_wd = rx_byte;
                              next_r.wr_pulse = 1'b1;
                           end else begin
                              // (RULE7) protect high keeps contents
                              next_r.wr_blocked = 1'b1;
                           end
                           // (RULE22) still acknowledged, address moves
                           next_r.ptr = r.ptr + 16'd1;
                        end
                     endcase
                     if (r.byten != 2'd3) begin
                        next_r.byten = r.byten + 2'd1;
                     end
                  end
               end else if (scl_fall && r.bitn == 4'd8) begin
                  // (RULE18) acknowledge on the ninth clock
                  next_r.st     = T_RACK;
                  next_r.sda_oe = 1'b1;
               end
            end
            T_RACK: begin
               if (scl_fall) begin
                  next_r.bitn = '0;
                  if (r.rd) begin
                     // (RULE9) reads ignore write protect
                     next_r.st     = T_TX;
                     next_r.sh     = rdata;
                     next_r.sda_oe = ~rdata[7];
                     next_r.ptr    = r.ptr + 16'd1;
                  end else begin
                     next_r.st     = T_RX;
                     next_r.sda_oe = 1'b0;
                  end
               end
            end
            T_TX: begin
               if (scl_rise) begin
                  next_r.bitn = r.bitn + 4'd1;
               end else if (scl_fall) begin
                  // (RULE12) data moves while clock low
                  if (r.bitn == 4'd8) begin
                     // (RULE18) release for master acknowledge
                     next_r.st     = T_MACK;
                     next_r.sda_oe = 1'b0;
                  end else begin
                     // (RULE5) only pull low, never drive high
                     next_r.sh     = {r.sh[6:0], 1'b0};
                     next_r.sda_oe = ~r.sh[6];
                  end
               end
            end
            T_MACK: begin
               if (scl_rise) begin
                  if (sda_in) begin
                     // not acknowledged: release and wait
                     next_r.st   = T_IDLE;
                     next_r.busy = 1'b0;
                  end else begin
                     // next fall loads the following byte
                     next_r.st = T_RACK;
                  end
               end
            end
            default: begin
               next_r.st     = T_IDLE;
               next_r.sda_oe = 1'b0;
               next_r.busy   = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         // (RULE3) select bits start low
         // (RULE10) protect starts low, writable
         r <= '{st: T_IDLE, s1: 6'h30, s2: 6'h30, s3: 6'h30,
                filt: 6'h30, sh: 8'h00, bitn: 4'h0, byten: 2'h0,
                rd: 1'b0, ptr: FMI_PTR_RST, sda_oe: 1'b0, busy: 1'b0,
                wr_pulse: 1'b0, wr_blocked: 1'b0};
      end else begin
         r <= next_r;
      end
   end

   // array has no reset: contents survive, as nonvolatile cells would
   always_ff @(posedge i_clk) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   // (RULE11) target never drives clock
   assign link.sda_t_oe = r.sda_oe;
   assign o_busy        = r.busy;
   assign o_wr_pulse    = r.wr_pulse;
   assign o_wr_blocked  = r.wr_blocked;
endmodule

// ### fmi_target_tb.sv
`timescale 1ns/1ps
`define check_eq(got, exp) \
   begin check_count++; if ((got) !== (exp)) begin fail_count++; \
   $display("mismatch at %0t got %0h exp %0h", $time, got, exp); end end
module fmi_target_tb;
   import fmi_pkg::*;
   logic                 i_clk;
   logic                 i_sys_rst;
   logic                 cmd_valid;
   logic [FMI_CMD_W-1:0] cmd_data;
   logic                 cmd_ready;
   logic                 m_busy;
   logic                 rd_valid;
   logic [7:0]           rd_data;
   logic                 ack_err;
   logic [2:0]           dev_sel;
   logic                 write_protect;
   logic                 t_busy;
   logic                 wr_pulse;
   logic                 wr_blocked;
   logic [7:0]           last_rd;
   int                   fail_count;
   int                   check_count;
   int                   n_wr;
   int                   n_blk;
   int                   n_err;

   fmi_link_if fmi_link_if_i ();
   fmi_master fmi_master_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .link(fmi_link_if_i), .i_cmd_valid(cmd_valid),
      .i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready), .o_busy(m_busy),
      .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_ack_err(ack_err));
   fmi_target fmi_target_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .link(fmi_link_if_i), .i_dev_sel(dev_sel),
      .i_write_protect(write_protect), .o_busy(t_busy),
      .o_wr_pulse(wr_pulse), .o_wr_blocked(wr_blocked));
   fmi_props fmi_props_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
      .scl(fmi_link_if_i.scl), .sda_m_oe(fmi_link_if_i.sda_m_oe),
      .sda_t_oe(fmi_link_if_i.sda_t_oe), .sda(fmi_link_if_i.sda));

   always #5 i_clk = ~i_clk;

   always @(negedge i_clk) begin
      if (wr_pulse === 1'b1) n_wr++;
      if (wr_blocked === 1'b1) n_blk++;
      if (ack_err === 1'b1) n_err++;
      if (rd_valid === 1'b1) last_rd = rd_data;
   end

   task close_out;
      if (fail_count == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // called at a falling edge; one idle cycle after, so valid never
   // drops and rises in one time step
   task push(input logic rw, input logic [2:0] sel,
             input logic [15:0] addr, input logic [7:0] data);
      cmd_valid = 1'b1;
      cmd_data  = {rw, sel, addr, data};
      while (cmd_ready !== 1'b1) @(negedge i_clk);
      @(negedge i_clk);
      cmd_valid = 1'b0;
      @(negedge i_clk);
   endtask

   task wait_idle;
      int idle;
      int guard;
      idle  = 0;
      guard = 0;
      while (idle < 60 && guard < 40000) begin
         @(negedge i_clk);
         guard++;
         if (m_busy === 1'b0 && t_busy === 1'b0) idle++;
         else idle = 0;
      end
      `check_eq(idle, 60)
   endtask

   task read_expect(input logic [15:0] addr, input logic [7:0] exp);
      int e0;
      e0 = n_err;
      push(FMI_DIR_READ, dev_sel, addr, 8'h00);
      wait_idle();
      `check_eq(last_rd, exp)
      `check_eq(n_err - e0, 0)
   endtask

   task scen_array_span;
      int w0;
      w0            = n_wr;
      write_protect = 1'b0;
      dev_sel       = 3'h5;
      push(FMI_DIR_WRITE, 3'h5, 16'hFFFF, 8'h5A);
      push(FMI_DIR_WRITE, 3'h5, 16'h0000, 8'hC3);
      read_expect(16'hFFFF, 8'h5A);
      read_expect(16'h0000, 8'hC3);
      `check_eq(n_wr - w0, 2)
   endtask

   task scen_protect;
      int w0;
      int b0;
      int e0;
      w0            = n_wr;
      b0            = n_blk;
      e0            = n_err;
      write_protect = 1'b1;
      push(FMI_DIR_WRITE, 3'h5, 16'hFFFF, 8'h11);
      wait_idle();
      `check_eq(n_wr - w0, 0)
      `check_eq(n_blk - b0, 1)
      `check_eq(n_err - e0, 0)
      read_expect(16'hFFFF, 8'h5A);
      write_protect = 1'b0;
   endtask

   task scen_select_codes;
      int w0;
      for (int s = 0; s < 8; s++) begin
         w0      = n_wr;
         dev_sel = s[2:0];
         push(FMI_DIR_WRITE, s[2:0], {13'h0000, s[2:0]}, 8'h3C);
         wait_idle();
         `check_eq(n_wr - w0, 1)
      end
      read_expect(16'h0007, 8'h3C);
   endtask

   // master drains one word per link transfer, so the queue fills
   task scen_fill_drain;
      int n;
      int w0;
      int e0;
      n         = 0;
      w0        = n_wr;
      e0        = n_err;
      dev_sel   = 3'h2;
      cmd_valid = 1'b1;
      cmd_data  = {FMI_DIR_WRITE, 3'h3, 16'h0100, 8'h77};
      while (cmd_ready === 1'b1 && n < 40) begin
         @(negedge i_clk);
         n++;
      end
      cmd_valid = 1'b0;
      `check_eq(n >= 16 && n <= 17, 1'b1)
      @(negedge i_clk);
      `check_eq(cmd_ready, 1'b0)
      wait_idle();
      `check_eq(n_err - e0, n)
      `check_eq(n_wr - w0, 0)
      `check_eq(cmd_ready, 1'b1)
   endtask

   initial begin
      i_clk         = 1'b0;
      i_sys_rst     = 1'b1;
      cmd_valid     = 1'b0;
      cmd_data      = '0;
      dev_sel       = 3'h0;
      write_protect = 1'b0;
      fail_count    = 0;
      check_count   = 0;
      n_wr          = 0;
      n_blk         = 0;
      n_err         = 0;
      last_rd       = 8'h00;
      repeat (12) @(negedge i_clk);
      i_sys_rst = 1'b0;
      @(negedge i_clk);
      scen_array_span();
      scen_protect();
      scen_select_codes();
      scen_fill_drain();
      close_out();
   end

   // whole sequence is about 80k clocks
   initial begin
      #950_000;
      fail_count++;
      close_out();
   end
endmodule
